// ---- hw/smie_pkg.sv ----
package smie_pkg;

    // Register byte offsets
    localparam logic [7:0] SMIE_OFS_CMD     = 8'h00;
    localparam logic [7:0] SMIE_OFS_ACC     = 8'h04;
    localparam logic [7:0] SMIE_OFS_FLAGS   = 8'h08;
    localparam logic [7:0] SMIE_OFS_BANK    = 8'h0C;
    localparam logic [7:0] SMIE_OFS_PAGE    = 8'h10;
    localparam logic [7:0] SMIE_OFS_PTR0    = 8'h14;
    localparam logic [7:0] SMIE_OFS_PTR1    = 8'h18;
    localparam logic [7:0] SMIE_OFS_MADDR   = 8'h1C;
    localparam logic [7:0] SMIE_OFS_MDATA   = 8'h20;

    // Flag register field positions
    localparam int SMIE_FLAG_C = 0;
    localparam int SMIE_FLAG_Z = 1;

    // Window file addresses
    localparam logic [6:0] SMIE_WIN0_ADDR = 7'h00;
    localparam logic [6:0] SMIE_WIN1_ADDR = 7'h01;

    // Values after reset
    localparam logic [7:0]  SMIE_ACC_RST  = 8'h00;
    localparam logic [4:0]  SMIE_BANK_RST = 5'h00;
    localparam logic [6:0]  SMIE_PAGE_RST = 7'h00;
    localparam logic [15:0] SMIE_PTR_RST  = 16'h0000;
    localparam logic [31:0] SMIE_CMD_RST  = 32'h0000_0000;
    localparam logic        SMIE_CARRY_RST = 1'b0;
    localparam logic        SMIE_ZERO_RST  = 1'b0;

    // Pointer mode codes
    localparam logic [1:0] SMIE_MODE_PRE_INC  = 2'h0;
    localparam logic [1:0] SMIE_MODE_PRE_DEC  = 2'h1;
    localparam logic [1:0] SMIE_MODE_POST_INC = 2'h2;
    localparam logic [1:0] SMIE_MODE_POST_DEC = 2'h3;

    typedef enum logic [2:0] {
        SMIE_OP_NOP   = 3'h0,
        SMIE_OP_LSR   = 3'h1,
        SMIE_OP_FILE_MOVE_OP  = 3'h2,
        SMIE_OP_INDLD = 3'h3,
        SMIE_OP_BANK  = 3'h4,
        SMIE_OP_PAGE  = 3'h5,
        SMIE_OP_LIT   = 3'h6
    } smie_op_t;

    // Command word written to the command register
    typedef struct packed {
        logic [9:0] unused;
        logic [5:0] offset;
        logic [7:0] operand;
        logic       relative;
        logic [1:0] pointer_mode_code;
        logic       ptr_sel;
        logic       dest;
        smie_op_t   op;
    } smie_cmd_t;

endpackage

// ---- hw/smie_exec.sv ----
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Right shift: result 6..0 from source 7..1, bit 7 zero, carry gets bit 0
// - Right shift updates carry and zero; zero always enters the top bit
// - Shift and file move: dest 0 writes accumulator, dest 1 writes file
// - File move copies the register to destination and updates zero
// - Indirect load reads pointer-addressed location into accumulator, updates zero
// - Mode code 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec
// - Pre modes access and keep stepped value; post modes access old, then step
// - Relative form accesses pointer plus signed offset, pointer unchanged
// - Window registers have no storage; access goes to pointer address
// - Pointers are 16 bits and wrap at both ends
// - Bank literal loads the 5-bit immediate into bank select, flags untouched
// - Page literal loads 7-bit immediate into upper latch, flags untouched
// - Accumulator literal loads 8-bit immediate, flags untouched
module smie_exec
    import smie_pkg::*;
#(
    parameter int MEM_AW = 8
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata,
    output logic      [7:0]  accumulator,
    output logic             carry_flag,
    output logic             zero_flag,
    output logic      [4:0]  bank_select_register,
    output logic      [6:0]  pc_upper_latch
);

    ////////////////////////////////////////////////////////////////////////

    localparam int MEM_DEPTH = 1 << MEM_AW;

    logic [7:0]        data_mem [MEM_DEPTH];

    smie_cmd_t         last_cmd;
    logic [15:0]       indirect_pointer [2];
    logic [15:0]       mem_addr;

    smie_cmd_t         next_last_cmd;
    logic [7:0]        next_accumulator;
    logic              next_carry_flag;
    logic              next_zero_flag;
    logic [4:0]        next_bank;
    logic [6:0]        next_page;
    logic [15:0]       next_ptr0;
    logic [15:0]       next_ptr1;
    logic [15:0]       next_mem_addr;
    logic [31:0]       next_rdata;

    logic              mem_we;
    logic [MEM_AW-1:0] mem_wa;
    logic [7:0]        mem_wd;

    ////////////////////////////////////////////////////////////////////////
    // Operand decode

    smie_cmd_t         cmd;
    logic              exec;
    logic [15:0]       sel_ptr;
    logic [15:0]       ptr_inc;
    logic [15:0]       ptr_dec;
    logic [15:0]       ptr_rel;
    logic [15:0]       ind_addr;
    logic [15:0]       ind_ptr_new;
    logic [6:0]        file_f;
    logic              file_is_win;
    logic [15:0]       file_addr;
    logic [7:0]        file_val;
    logic [7:0]        ind_val;
    logic [7:0]        shift_res;

    assign cmd    = smie_cmd_t'(wdata);
    assign exec   = wr_stb && (addr == SMIE_OFS_CMD);
    assign file_f = cmd.operand[6:0];

    // Window addresses resolve through the pointer, never to storage
    assign file_is_win = (file_f == SMIE_WIN0_ADDR)
                      || (file_f == SMIE_WIN1_ADDR);
    assign file_addr   = (file_f == SMIE_WIN0_ADDR) ? indirect_pointer[0]
                       : (file_f == SMIE_WIN1_ADDR) ? indirect_pointer[1]
                       : {4'h0, bank_select_register, file_f};

    assign file_val  = data_mem[file_addr[MEM_AW-1:0]];
    assign shift_res = {1'b0, file_val[7:1]};

    assign sel_ptr = indirect_pointer[cmd.ptr_sel];
    // Plain 16-bit arithmetic wraps at 0000h and FFFFh
    assign ptr_inc = 16'(sel_ptr + 16'h0001);
    assign ptr_dec = 16'(sel_ptr - 16'h0001);
    // Offset sign-extended; relative form never moves the pointer
    assign ptr_rel = 16'(sel_ptr + {{10{cmd.offset[5]}}, cmd.offset});

    always_comb begin
        ind_addr    = sel_ptr;
        ind_ptr_new = sel_ptr;
        if (cmd.relative) begin
            ind_addr    = ptr_rel;
            ind_ptr_new = sel_ptr;
        end else begin
            case (cmd.pointer_mode_code)
                SMIE_MODE_PRE_INC: begin
                    ind_addr    = ptr_inc;
                    ind_ptr_new = ptr_inc;
                end
                SMIE_MODE_PRE_DEC: begin
                    ind_addr    = ptr_dec;
                    ind_ptr_new = ptr_dec;
                end
                SMIE_MODE_POST_INC: begin
                    ind_addr    = sel_ptr;
                    ind_ptr_new = ptr_inc;
                end
                default: begin
                    ind_addr    = sel_ptr;
                    ind_ptr_new = ptr_dec;
                end
            endcase
        end
    end

    assign ind_val = data_mem[ind_addr[MEM_AW-1:0]];

    ////////////////////////////////////////////////////////////////////////
    // Execution and register writes

    always_comb begin
        next_last_cmd    = last_cmd;
        next_accumulator = accumulator;
        next_carry_flag  = carry_flag;
        next_zero_flag   = zero_flag;
        next_bank        = bank_select_register;
        next_page        = pc_upper_latch;
        next_ptr0        = indirect_pointer[0];
        next_ptr1        = indirect_pointer[1];
        next_mem_addr    = mem_addr;
        mem_we           = 1'b0;
        mem_wa           = file_addr[MEM_AW-1:0];
        mem_wd           = 8'h00;

        if (exec) begin
            next_last_cmd = cmd;
            case (cmd.op)
                SMIE_OP_LSR: begin
                    next_carry_flag = file_val[0];
                    next_zero_flag  = (shift_res == 8'h00);
                    if (cmd.dest) begin
                        mem_we = 1'b1;
                        mem_wd = shift_res;
                    end else begin
                        next_accumulator = shift_res;
                    end
                end
                SMIE_OP_FILE_MOVE_OP: begin
                    next_zero_flag = (file_val == 8'h00);
                    if (cmd.dest) begin
                        mem_we = 1'b1;
                        mem_wd = file_val;
                    end else begin
                        next_accumulator = file_val;
                    end
                end
                SMIE_OP_INDLD: begin
                    next_accumulator = ind_val;
                    next_zero_flag   = (ind_val == 8'h00);
                    // Pointer stepping leaves carry alone
                    if (cmd.ptr_sel) begin
                        next_ptr1 = ind_ptr_new;
                    end else begin
                        next_ptr0 = ind_ptr_new;
                    end
                end
                SMIE_OP_BANK: begin
                    next_bank = cmd.operand[4:0];
                end
                SMIE_OP_PAGE: begin
                    next_page = cmd.operand[6:0];
                end
                SMIE_OP_LIT: begin
                    next_accumulator = cmd.operand;
                end
                default: begin
                    next_last_cmd = cmd;
                end
            endcase
        end else if (wr_stb) begin
            if (addr == SMIE_OFS_ACC) begin
                next_accumulator = wdata[7:0];
            end else if (addr == SMIE_OFS_FLAGS) begin
                next_carry_flag = wdata[SMIE_FLAG_C];
                next_zero_flag  = wdata[SMIE_FLAG_Z];
            end else if (addr == SMIE_OFS_BANK) begin
                next_bank = wdata[4:0];
            end else if (addr == SMIE_OFS_PAGE) begin
                next_page = wdata[6:0];
            end else if (addr == SMIE_OFS_PTR0) begin
                next_ptr0 = wdata[15:0];
            end else if (addr == SMIE_OFS_PTR1) begin
                next_ptr1 = wdata[15:0];
            end else if (addr == SMIE_OFS_MADDR) begin
                next_mem_addr = wdata[15:0];
            end else if (addr == SMIE_OFS_MDATA) begin
                mem_we = 1'b1;
                mem_wa = mem_addr[MEM_AW-1:0];
                mem_wd = wdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe

    // Unmapped reads give zero so software never sees stale data
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (rd_stb) begin
            if (addr == SMIE_OFS_CMD) begin
                next_rdata = 32'(last_cmd);
            end else if (addr == SMIE_OFS_ACC) begin
                next_rdata = {24'h00_0000, accumulator};
            end else if (addr == SMIE_OFS_FLAGS) begin
                next_rdata = {30'h0000_0000, zero_flag, carry_flag};
            end else if (addr == SMIE_OFS_BANK) begin
                next_rdata = {27'h000_0000, bank_select_register};
            end else if (addr == SMIE_OFS_PAGE) begin
                next_rdata = {25'h000_0000, pc_upper_latch};
            end else if (addr == SMIE_OFS_PTR0) begin
                next_rdata = {16'h0000, indirect_pointer[0]};
            end else if (addr == SMIE_OFS_PTR1) begin
                next_rdata = {16'h0000, indirect_pointer[1]};
            end else if (addr == SMIE_OFS_MADDR) begin
                next_rdata = {16'h0000, mem_addr};
            end else if (addr == SMIE_OFS_MDATA) begin
                next_rdata = {24'h00_0000, data_mem[mem_addr[MEM_AW-1:0]]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers

    // Last command, kept only for read-back
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            last_cmd <= smie_cmd_t'(SMIE_CMD_RST);
        end else begin
            last_cmd <= next_last_cmd;
        end
    end

    // Accumulator
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            accumulator <= SMIE_ACC_RST;
        end else begin
            accumulator <= next_accumulator;
        end
    end

    // Flags; only commands and direct writes move them
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            carry_flag <= SMIE_CARRY_RST;
            zero_flag  <= SMIE_ZERO_RST;
        end else begin
            carry_flag <= next_carry_flag;
            zero_flag  <= next_zero_flag;
        end
    end

    // Bank select
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bank_select_register <= SMIE_BANK_RST;
        end else begin
            bank_select_register <= next_bank;
        end
    end

    // Program counter upper latch
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pc_upper_latch <= SMIE_PAGE_RST;
        end else begin
            pc_upper_latch <= next_page;
        end
    end

    // Pointer 0
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            indirect_pointer[0] <= SMIE_PTR_RST;
        end else begin
            indirect_pointer[0] <= next_ptr0;
        end
    end

    // Pointer 1
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            indirect_pointer[1] <= SMIE_PTR_RST;
        end else begin
            indirect_pointer[1] <= next_ptr1;
        end
    end

    // Debug memory address
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mem_addr <= SMIE_PTR_RST;
        end else begin
            mem_addr <= next_mem_addr;
        end
    end

    // Read data stands one cycle, then falls back to zero
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // Data memory has no reset; contents are undefined until written
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            data_mem[mem_wa] <= mem_wd;
        end
    end

    // Unused command bits are ignored
    logic unused_ok;
    assign unused_ok = ^{cmd.unused, file_is_win};

endmodule

`default_nettype wire

// ---- tb/smie_exec_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module smie_exec_checker
    import smie_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_stb,
    input wire logic        rd_stb,
    input wire logic [31:0] rdata,
    input wire logic [7:0]  accumulator,
    input wire logic        carry_flag,
    input wire logic        zero_flag,
    input wire logic [4:0]  bank_select_register,
    input wire logic [6:0]  pc_upper_latch
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_cmd(logic [2:0] o);
        wr_stb && addr == SMIE_OFS_CMD && wdata[2:0] == o;
    endsequence
    // Literal loads must leave both flags alone
    sequence s_kept;
        $stable(carry_flag) && $stable(zero_flag);
    endsequence
    AST_LSR_ACC: assert property (s_cmd(SMIE_OP_LSR) ##0 !wdata[3] |=>
        !accumulator[7] && zero_flag == (accumulator == 8'h00))
        else $error("shift result bad");
    AST_MOVE_BACK: assert property (s_cmd(SMIE_OP_FILE_MOVE_OP) ##0 wdata[3]
        |=> $stable(accumulator)) else $error("move to file hit acc");
    AST_MOVE_ZERO: assert property (s_cmd(SMIE_OP_FILE_MOVE_OP) ##0 !wdata[3]
        |=> zero_flag == (accumulator == 8'h00)) else $error("move zero bad");
    AST_IND_LOAD: assert property (s_cmd(SMIE_OP_INDLD) |=>
        zero_flag == (accumulator == 8'h00) && $stable(carry_flag))
        else $error("indirect load flags bad");
    AST_BANK: assert property (s_cmd(SMIE_OP_BANK) |=>
        bank_select_register == $past(wdata[12:8]) ##0 s_kept)
        else $error("bank literal bad");
    AST_PAGE: assert property (s_cmd(SMIE_OP_PAGE) |=>
        pc_upper_latch == $past(wdata[14:8]) ##0 s_kept)
        else $error("page literal bad");
    AST_LIT: assert property (s_cmd(SMIE_OP_LIT) |=>
        accumulator == $past(wdata[15:8]) ##0 s_kept)
        else $error("acc literal bad");
    AST_RD_IDLE: assert property (!rd_stb |=> rdata == 32'h0)
        else $error("read data not idle");
endmodule
bind smie_exec smie_exec_checker u_chk (.ref_clk, .reset, .addr, .wdata,
    .wr_stb, .rd_stb, .rdata, .accumulator, .carry_flag, .zero_flag,
    .bank_select_register, .pc_upper_latch);
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb
    import smie_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        wr_stb  = 1'b0;
    logic        rd_stb  = 1'b0;
    logic [31:0] rdata;
    logic [7:0]  accumulator;
    logic        carry_flag;
    logic        zero_flag;
    logic [4:0]  bank_select_register;
    logic [6:0]  pc_upper_latch;
    logic        rd_d    = 1'b0;
    logic [7:0]  qa[$];
    logic [31:0] qe[$];
    logic [7:0]  mem_m[256];
    logic [7:0]  v;
    logic [7:0]  acc_m   = 8'h00;
    logic [5:0]  o;
    logic [15:0] p;
    logic [15:0] ea;
    logic [15:0] np;
    logic [7:0]  pa;
    int          n_fail  = 0;
    int          n_checks = 0;
    integer      seed    = 32'h994b;
    always #2.5 ref_clk = ~ref_clk;
    smie_exec uut (.ref_clk, .reset, .addr, .wdata, .wr_stb, .rd_stb,
        .rdata, .accumulator, .carry_flag, .zero_flag,
        .bank_select_register, .pc_upper_latch);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] cmd(logic [2:0] op, logic d, logic s,
        logic [1:0] m, logic r, logic [7:0] k, logic [5:0] off);
        return {10'h000, off, k, r, m, s, d, op};
    endfunction
    task automatic chk(logic [7:0] a, logic [31:0] s, logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("ERROR reg %h exp %h got %h", a, e, s);
        end
    endtask
    // Strobes held between calls so no signal is set twice in a step
    task automatic wr(logic [7:0] a, logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        rd_stb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e);
        qa.push_back(a);
        qe.push_back(e);
        addr <= a;
        rd_stb <= 1'b1;
        wr_stb <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic set_mem(logic [7:0] a, logic [7:0] d);
        wr(SMIE_OFS_MADDR, {24'h0, a});
        wr(SMIE_OFS_MDATA, {24'h0, d});
        mem_m[a] = d;
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        if (rd_d) chk(qa.pop_front(), rdata, qe.pop_front());
        rd_d <= rd_stb;
    end
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_fail++;
        print_verdict;
    end
    initial begin
        repeat (3) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        rd(SMIE_OFS_FLAGS, 32'h0);
        rd(SMIE_OFS_PTR1, 32'h0);
        wr(8'h30, 32'hFF);
        rd(8'h30, 32'h0);
        wr(SMIE_OFS_FLAGS, 32'h3);
        v = 8'($random(seed));
        wr(SMIE_OFS_CMD, cmd(SMIE_OP_LIT, 0, 0, 0, 0, v, 0));
        rd(SMIE_OFS_ACC, {24'h0, v});
        wr(SMIE_OFS_CMD, cmd(SMIE_OP_BANK, 0, 0, 0, 0, 8'h0F, 0));
        rd(SMIE_OFS_BANK, 32'hF);
        wr(SMIE_OFS_CMD, cmd(SMIE_OP_PAGE, 0, 0, 0, 0, 8'hFF, 0));
        rd(SMIE_OFS_PAGE, 32'h7F);
        rd(SMIE_OFS_FLAGS, 32'h3);
        wr(SMIE_OFS_CMD, cmd(SMIE_OP_BANK, 0, 0, 0, 0, 8'h00, 0));
        acc_m = v;
        // Shift then move on one file; dest alternates
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'h01 : (i == 1) ? 8'h00 : 8'($random(seed));
            set_mem(8'h10, v);
            wr(SMIE_OFS_CMD, cmd(SMIE_OP_LSR, i[0], 0, 0, 0, 8'h10, 0));
            if (i[0]) mem_m[16] = v >> 1;
            else acc_m = v >> 1;
            rd(SMIE_OFS_ACC, {24'h0, acc_m});
            rd(SMIE_OFS_FLAGS, {30'h0, (v >> 1) == 8'h00, v[0]});
            rd(SMIE_OFS_MDATA, {24'h0, mem_m[16]});
            wr(SMIE_OFS_CMD, cmd(SMIE_OP_FILE_MOVE_OP, !i[0], 0, 0, 0, 8'h10, 0));
            if (i[0]) acc_m = mem_m[16];
            rd(SMIE_OFS_ACC, {24'h0, acc_m});
            rd(SMIE_OFS_FLAGS, {30'h0, mem_m[16] == 8'h00, v[0]});
        end
        // Four step modes at the wrap points, then both offset bounds
        wr(SMIE_OFS_FLAGS, 32'h1);
        for (int m = 0; m < 6; m++) begin
            p = (m > 3) ? 16'h0010 : m[0] ? 16'h0000 : 16'hFFFF;
            o = (m == 4) ? 6'h20 : 6'h1F;
            np = (m > 3) ? p : m[0] ? p - 16'h1 : p + 16'h1;
            ea = (m > 3) ? p + {{10{o[5]}}, o} : m[1] ? p : np;
            v = (m == 3) ? 8'h00 : 8'($random(seed));
            pa = m[0] ? SMIE_OFS_PTR1 : SMIE_OFS_PTR0;
            set_mem(ea[7:0], v);
            wr(pa, {16'h0, p});
            wr(SMIE_OFS_CMD,
               cmd(SMIE_OP_INDLD, 0, m[0], m[1:0], m > 3, 8'h00, o));
            rd(SMIE_OFS_ACC, {24'h0, v});
            rd(pa, {16'h0, np});
            rd(SMIE_OFS_FLAGS, {30'h0, v == 8'h00, 1'b1});
        end
        // Window access lands on the pointed-to byte
        wr(SMIE_OFS_PTR0, 32'h0123);
        v = 8'($random(seed));
        set_mem(8'h23, v);
        wr(SMIE_OFS_CMD, cmd(SMIE_OP_FILE_MOVE_OP, 0, 0, 0, 0, 8'h00, 0));
        rd(SMIE_OFS_ACC, {24'h0, v});
        wr(SMIE_OFS_CMD, cmd(SMIE_OP_LSR, 1, 0, 0, 0, 8'h00, 0));
        rd(SMIE_OFS_MDATA, {24'h0, v >> 1});
        wr_stb <= 1'b0;
        rd_stb <= 1'b0;
        repeat (3) @(posedge ref_clk);
        print_verdict;
    end
endmodule
`default_nettype wire
